// File: sfpx_ovf_default.sv
// sfpx_ovf_default: default result of a masked overflow.
// assumes: combinational, result consumed by a registering parent.
`timescale 1ns/10ps
module sfpx_ovf_default import sfpx_pkg::*; (
	// operation
	input wire logic dbl_in,
	input wire logic sign_in,
	input wire logic [1:0] rnd_mode_in,
	// result
	output logic [RES_W-1:0] res_out
);
	logic to_inf;

	always_comb begin
		// infinity unless rounding leans toward zero for this sign
		to_inf = (rnd_mode_in == RND_NEAREST) ||
			(rnd_mode_in == RND_DOWN && sign_in) ||
			(rnd_mode_in == RND_UP && !sign_in);
		if (dbl_in) begin
			res_out = to_inf ? {sign_in, DBL_EXPF_INF, {FRAC_W{1'b0}}} :
				{sign_in, DBL_EXPF_MAX, {FRAC_W{1'b1}}};
		end else begin
			res_out = to_inf ? {{SGL_W{1'b0}}, sign_in, SGL_EXPF_INF, {SGL_FRAC_W{1'b0}}} :
				{{SGL_W{1'b0}}, sign_in, SGL_EXPF_MAX, {SGL_FRAC_W{1'b1}}};
		end
	end
endmodule

// File: sfpx_pkg.sv
// sfpx_pkg: constants and types of the post-computation exception unit.
// assumes: the upstream rounder delivers the unbounded exponent unbiased.
package sfpx_pkg;

	// result word and exponent widths
	localparam int RES_W = 64;
	localparam int EXP_W = 14;
	localparam int FRAC_W = 52;
	localparam int SGL_FRAC_W = 23;
	localparam int SGL_EXPF_W = 8;
	localparam int DBL_EXPF_W = 11;
	localparam int SGL_W = 32;

	// single-precision fraction sits in the top bits of the frac input
	localparam int SGL_FRAC_LSB = FRAC_W - SGL_FRAC_W;

	// rounding-mode field of the control/status word
	localparam logic [1:0] RND_NEAREST = 2'h0;
	localparam logic [1:0] RND_DOWN = 2'h1;
	localparam logic [1:0] RND_UP = 2'h2;
	localparam logic [1:0] RND_ZERO = 2'h3;

	// normal exponent range, unbiased
	localparam logic signed [EXP_W-1:0] SGL_EMAX = 14'sh007F;
	localparam logic signed [EXP_W-1:0] SGL_EMIN = -14'sh007E;
	localparam logic signed [EXP_W-1:0] DBL_EMAX = 14'sh03FF;
	localparam logic signed [EXP_W-1:0] DBL_EMIN = -14'sh03FE;
	localparam logic signed [EXP_W-1:0] SGL_BIAS = 14'sh007F;
	localparam logic signed [EXP_W-1:0] DBL_BIAS = 14'sh03FF;

	// trap scaling exponents: 2^192 single, 2^1536 double
	localparam logic signed [EXP_W-1:0] SGL_SCALE = 14'sh00C0;
	localparam logic signed [EXP_W-1:0] DBL_SCALE = 14'sh0600;

	// exponent field codes
	localparam logic [SGL_EXPF_W-1:0] SGL_EXPF_INF = 8'hFF;
	localparam logic [SGL_EXPF_W-1:0] SGL_EXPF_MAX = 8'hFE;
	localparam logic [DBL_EXPF_W-1:0] DBL_EXPF_INF = 11'h7FF;
	localparam logic [DBL_EXPF_W-1:0] DBL_EXPF_MAX = 11'h7FE;

	// flag and cause bit positions
	localparam int FLAG_W = 3;
	localparam int FLG_OVF = 0;
	localparam int FLG_UNF = 1;
	localparam int FLG_PREC = 2;

	// operation classes
	typedef enum logic [2:0] {
		OP_ARITH = 3'h0,
		OP_NARROW = 3'h1,
		OP_SQRT = 3'h2,
		OP_TO_INT = 3'h3,
		OP_TO_INT_TRUNC = 3'h4,
		OP_FROM_INT = 3'h5
	} sfpx_op_type;

	typedef struct packed {
		logic [FLAG_W-1:0] flags;
		logic [RES_W-1:0] res;
		logic res_valid;
		logic exc_event;
		logic [FLAG_W-1:0] cause;
	} sfpx_state_type;

endpackage

// File: sfpx_post_exc.sv
// sfpx_post_exc: post-computation overflow, underflow and inexact handling.
// assumes: upstream rounder gives both the unbounded and bounded results.
`timescale 1ns/10ps
module sfpx_post_exc import sfpx_pkg::*; (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// control/status word fields
	input wire logic [1:0] ctl_rnd_mode_in,
	input wire logic [FLAG_W-1:0] ctl_mask_in,
	input wire logic [FLAG_W-1:0] flag_clear_in,
	// operation from the rounder
	input wire logic op_valid_in,
	input wire sfpx_op_type op_class_in,
	input wire logic op_dbl_in,
	input wire logic res_sign_in,
	input wire logic signed [EXP_W-1:0] res_exp_in,
	input wire logic [FRAC_W-1:0] res_frac_in,
	input wire logic res_inexact_in,
	input wire logic [RES_W-1:0] bnd_res_in,
	input wire logic bnd_inexact_in,
	// result
	output logic res_valid_out,
	output logic [RES_W-1:0] res_out,
	// status
	output logic [FLAG_W-1:0] sticky_flags_out,
	output logic exc_event_out,
	output logic [FLAG_W-1:0] exc_cause_out
);
	sfpx_state_type st_reg;
	sfpx_state_type st_next;

	logic ranged;
	logic dbl_eff;
	logic [1:0] rnd_eff;
	logic signed [EXP_W-1:0] emax;
	logic signed [EXP_W-1:0] emin;
	logic ovf;
	logic unf;
	logic ovf_trap;
	logic unf_trap;
	logic [FLAG_W-1:0] set_flags;
	logic [RES_W-1:0] ovf_default;
	logic [RES_W-1:0] scaled_res;

	// true when a flag bit is unmasked
	function automatic logic unmasked(input logic [FLAG_W-1:0] mask, input int idx);
		unmasked = !mask[idx];
	endfunction

	// operation decode
	always_comb begin
		// only fp-result arithmetic and narrowing can leave the range
		ranged = (op_class_in == OP_ARITH) || (op_class_in == OP_NARROW);
		// narrowing always lands in single precision
		dbl_eff = op_dbl_in && (op_class_in == OP_ARITH);
		// truncating conversions ignore the user mode
		rnd_eff = (op_class_in == OP_TO_INT_TRUNC) ? RND_ZERO : ctl_rnd_mode_in;
		emax = dbl_eff ? DBL_EMAX : SGL_EMAX;
		emin = dbl_eff ? DBL_EMIN : SGL_EMIN;
		ovf = op_valid_in && ranged && (res_exp_in > emax);
		unf = op_valid_in && ranged && (res_exp_in < emin);
		ovf_trap = ovf && unmasked(ctl_mask_in, FLG_OVF);
		unf_trap = unf && unmasked(ctl_mask_in, FLG_UNF);
	end

	sfpx_ovf_default u_ovf_default (
		.dbl_in(dbl_eff),
		.sign_in(res_sign_in),
		.rnd_mode_in(rnd_eff),
		.res_out(ovf_default)
	);

	sfpx_scale_pack u_scale_pack (
		.dbl_in(dbl_eff),
		.sign_in(res_sign_in),
		.exp_in(res_exp_in),
		.frac_in(res_frac_in),
		.scale_up_in(unf_trap),
		.res_out(scaled_res)
	);

	// response selection and flag update
	always_comb begin
		st_next = st_reg;
		st_next.res_valid = 1'b0;
		st_next.exc_event = 1'b0;
		set_flags = '0;
		if (op_valid_in) begin
			st_next.res_valid = 1'b1;
			st_next.cause = '0;
			if (ovf_trap) begin
				// trap takes the scaled value; inexact trap is suppressed
				st_next.res = scaled_res;
				set_flags[FLG_OVF] = 1'b1;
				set_flags[FLG_PREC] = res_inexact_in;
				st_next.cause[FLG_OVF] = 1'b1;
			end else if (unf_trap) begin
				st_next.res = scaled_res;
				set_flags[FLG_UNF] = 1'b1;
				set_flags[FLG_PREC] = res_inexact_in;
				st_next.cause[FLG_UNF] = 1'b1;
			end else begin
				if (ovf) begin
					// masked overflow is always inexact
					st_next.res = ovf_default;
					set_flags[FLG_OVF] = 1'b1;
					set_flags[FLG_PREC] = 1'b1;
				end else if (unf) begin
					// exact tiny results raise nothing
					st_next.res = bnd_res_in;
					set_flags[FLG_UNF] = bnd_inexact_in;
					set_flags[FLG_PREC] = bnd_inexact_in;
				end else begin
					st_next.res = bnd_res_in;
					set_flags[FLG_PREC] = res_inexact_in;
				end
				st_next.cause[FLG_PREC] = set_flags[FLG_PREC] &&
					unmasked(ctl_mask_in, FLG_PREC);
			end
			st_next.exc_event = |st_next.cause;
		end
		// a set arriving with its clear wins
		st_next.flags = (st_reg.flags & ~flag_clear_in) | set_flags;
	end

	// the whole state freezes while the clock enable is low
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_reg <= '0;
		end else if (ce_in) begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		res_valid_out = st_reg.res_valid;
		res_out = st_reg.res;
		sticky_flags_out = st_reg.flags;
		exc_event_out = st_reg.exc_event;
		exc_cause_out = st_reg.cause;
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);

	sequence masked_sgl_ovf_s(logic [1:0] rm);
		ce_in && op_valid_in && op_class_in == OP_ARITH && !op_dbl_in &&
			res_exp_in > SGL_EMAX && ctl_mask_in[FLG_OVF] && ctl_rnd_mode_in == rm;
	endsequence

	sequence unmasked_sgl_ovf_s;
		ce_in && op_valid_in && op_class_in == OP_NARROW &&
			res_exp_in > SGL_EMAX && !ctl_mask_in[FLG_OVF];
	endsequence

	ovf_nearest_inf_a: assert property (
		masked_sgl_ovf_s(RND_NEAREST) |=>
			res_out[SGL_W-2:0] == {SGL_EXPF_INF, {SGL_FRAC_W{1'b0}}} &&
			sticky_flags_out[FLG_OVF] && sticky_flags_out[FLG_PREC])
		else $error("masked overflow in nearest mode did not give infinity");

	ovf_zero_max_a: assert property (
		masked_sgl_ovf_s(RND_ZERO) |=>
			res_out[SGL_W-2:0] == {SGL_EXPF_MAX, {SGL_FRAC_W{1'b1}}})
		else $error("masked overflow toward zero did not give max finite");

	ovf_dbl_down_a: assert property (
		ce_in && op_valid_in && op_class_in == OP_ARITH && op_dbl_in &&
			res_exp_in > DBL_EMAX && ctl_mask_in[FLG_OVF] &&
			ctl_rnd_mode_in == RND_DOWN && !res_sign_in |=>
			res_out == {1'b0, DBL_EXPF_MAX, {FRAC_W{1'b1}}})
		else $error("masked double overflow downward did not give max finite");

	ovf_trap_scale_a: assert property (
		unmasked_sgl_ovf_s |=>
			exc_event_out && exc_cause_out == 3'h1 &&
			$signed({6'h00, res_out[SGL_W-2:SGL_FRAC_W]}) ==
				$past(res_exp_in) + SGL_BIAS - SGL_SCALE)
		else $error("unmasked overflow trap or scaled exponent wrong");

	unf_exact_quiet_a: assert property (
		ce_in && op_valid_in && op_class_in == OP_ARITH && res_exp_in < DBL_EMIN &&
			ctl_mask_in[FLG_UNF] && !bnd_inexact_in && flag_clear_in == 3'h0 |=>
			sticky_flags_out == $past(sticky_flags_out) && !exc_event_out)
		else $error("exact masked underflow changed a flag");

	trap_priority_a: assert property (
		ce_in && op_valid_in && ovf_trap && res_inexact_in && !ctl_mask_in[FLG_PREC] |=>
			!exc_cause_out[FLG_PREC] ##1 !exc_event_out || res_valid_out)
		else $error("inexact trap taken over an unmasked overflow");

	sticky_hold_a: assert property (
		sticky_flags_out[FLG_PREC] && ce_in && !flag_clear_in[FLG_PREC] |=>
			sticky_flags_out[FLG_PREC] [*1])
		else $error("precision flag dropped without a clear");

	set_wins_a: assert property (
		ce_in && flag_clear_in[FLG_OVF] && ovf |=> sticky_flags_out[FLG_OVF])
		else $error("overflow flag lost to a simultaneous clear");

	sqrt_inexact_a: assert property (
		ce_in && op_valid_in && op_class_in == OP_SQRT && res_inexact_in |=>
			sticky_flags_out[FLG_PREC] && res_out == $past(bnd_res_in) &&
			exc_event_out == !$past(ctl_mask_in[FLG_PREC]))
		else $error("inexact square root handled wrongly");

	trunc_no_range_a: assert property (
		ce_in && op_valid_in && op_class_in == OP_TO_INT_TRUNC |=>
			!exc_cause_out[FLG_OVF] && !exc_cause_out[FLG_UNF])
		else $error("truncating conversion raised a range trap");

	event_pulse_a: assert property (
		ce_in && !op_valid_in |=> !exc_event_out && !res_valid_out)
		else $error("event or valid without an operation");

	sequence unmasked_sgl_unf_s;
		ce_in && op_valid_in && op_class_in == OP_ARITH && !op_dbl_in &&
			res_exp_in < SGL_EMIN && !ctl_mask_in[FLG_UNF];
	endsequence

	sequence unmasked_dbl_ovf_s;
		ce_in && op_valid_in && op_class_in == OP_ARITH && op_dbl_in &&
			res_exp_in > DBL_EMAX && !ctl_mask_in[FLG_OVF];
	endsequence

	sequence unmasked_dbl_unf_s;
		ce_in && op_valid_in && op_class_in == OP_ARITH && op_dbl_in &&
			res_exp_in < DBL_EMIN && !ctl_mask_in[FLG_UNF];
	endsequence

	sequence plain_inexact_s;
		ce_in && op_valid_in && !ovf && !unf && res_inexact_in;
	endsequence

	// a trap keeps sign and fraction, only the exponent moves
	unf_sgl_scale_a: assert property (
		unmasked_sgl_unf_s |=>
			exc_event_out && exc_cause_out[FLG_UNF] && $onehot(exc_cause_out) &&
			sticky_flags_out[FLG_UNF] && res_out[SGL_W-1] == $past(res_sign_in) &&
			res_out[SGL_FRAC_W-1:0] == $past(res_frac_in[FRAC_W-1:SGL_FRAC_LSB]) &&
			$signed({6'h00, res_out[SGL_W-2:SGL_FRAC_W]}) ==
				$past(res_exp_in) + SGL_BIAS + SGL_SCALE)
		else $error("unmasked single underflow trap or scaled result wrong");

	dbl_ovf_scale_a: assert property (
		unmasked_dbl_ovf_s |=>
			exc_event_out && exc_cause_out[FLG_OVF] && $onehot(exc_cause_out) &&
			res_out[FRAC_W-1:0] == $past(res_frac_in) &&
			$signed({3'h0, res_out[RES_W-2:FRAC_W]}) ==
				$past(res_exp_in) + DBL_BIAS - DBL_SCALE)
		else $error("unmasked double overflow trap or scaled result wrong");

	dbl_unf_scale_a: assert property (
		unmasked_dbl_unf_s |=>
			exc_event_out && exc_cause_out[FLG_UNF] && $onehot(exc_cause_out) &&
			res_out[FRAC_W-1:0] == $past(res_frac_in) &&
			$signed({3'h0, res_out[RES_W-2:FRAC_W]}) ==
				$past(res_exp_in) + DBL_BIAS + DBL_SCALE)
		else $error("unmasked double underflow trap or scaled result wrong");

	unf_masked_flags_a: assert property (
		ce_in && op_valid_in && unf && ctl_mask_in[FLG_UNF] && bnd_inexact_in |=>
			sticky_flags_out[FLG_UNF] && sticky_flags_out[FLG_PREC] &&
			!exc_cause_out[FLG_UNF] && res_out == $past(bnd_res_in))
		else $error("inexact masked underflow lost a flag or its result");

	prec_trap_ovf_a: assert property (
		ce_in && ovf && !dbl_eff && ctl_mask_in[FLG_OVF] && !ctl_mask_in[FLG_PREC] |=>
			exc_event_out && exc_cause_out[FLG_PREC] && $onehot(exc_cause_out) &&
			sticky_flags_out[FLG_OVF] && (&res_out[SGL_W-2:SGL_FRAC_W+1]))
		else $error("inexact trap with masked overflow lost the default result");

	prec_trap_unf_a: assert property (
		ce_in && unf && ctl_mask_in[FLG_UNF] && !ctl_mask_in[FLG_PREC] && bnd_inexact_in |=>
			exc_event_out && exc_cause_out[FLG_PREC] && $onehot(exc_cause_out) &&
			sticky_flags_out[FLG_UNF] && res_out == $past(bnd_res_in))
		else $error("inexact trap with masked underflow lost its result");

	prec_masked_a: assert property (
		plain_inexact_s ##0 ctl_mask_in[FLG_PREC] |=>
			sticky_flags_out[FLG_PREC] && !exc_event_out && res_out == $past(bnd_res_in))
		else $error("masked inexact result or flag wrong");

	prec_trap_plain_a: assert property (
		plain_inexact_s ##0 !ctl_mask_in[FLG_PREC] |=>
			exc_event_out && exc_cause_out[FLG_PREC] && $onehot(exc_cause_out) &&
			sticky_flags_out[FLG_PREC] && res_out == $past(bnd_res_in))
		else $error("inexact trap without a range condition wrong");

	ovf_edge_a: assert property (
		ce_in && op_valid_in && op_class_in == OP_ARITH &&
			res_exp_in == (op_dbl_in ? DBL_EMAX : SGL_EMAX) |=>
			!exc_cause_out[FLG_OVF] && res_out == $past(bnd_res_in))
		else $error("largest normal exponent taken as overflow");

	unf_edge_a: assert property (
		ce_in && op_valid_in && op_class_in == OP_ARITH && bnd_inexact_in &&
			res_exp_in == (op_dbl_in ? DBL_EMIN : SGL_EMIN) && !flag_clear_in[FLG_UNF] |=>
			!exc_cause_out[FLG_UNF] &&
			sticky_flags_out[FLG_UNF] == $past(sticky_flags_out[FLG_UNF]))
		else $error("smallest normal exponent taken as underflow");

	narrow_range_a: assert property (
		ce_in && op_valid_in && op_class_in == OP_NARROW && res_exp_in > SGL_EMAX &&
			ctl_mask_in[FLG_OVF] |=>
			sticky_flags_out[FLG_OVF] && sticky_flags_out[FLG_PREC] &&
			res_out[RES_W-1:SGL_W] == '0 && (&res_out[SGL_W-2:SGL_FRAC_W+1]))
		else $error("narrowing overflow not handled in single format");

	trap_event_a: assert property (
		ce_in && (ovf_trap || unf_trap) |=>
			exc_event_out && res_valid_out && $onehot(exc_cause_out))
		else $error("unmasked range condition raised no event");

	flag_clear_a: assert property (
		ce_in && flag_clear_in[FLG_PREC] && !set_flags[FLG_PREC] |=>
			!sticky_flags_out[FLG_PREC])
		else $error("precision flag survived its clear");

	// frozen enable holds every output, pulses included
	ce_freeze_a: assert property (
		!ce_in |=> $stable(res_out) && $stable(sticky_flags_out) && $stable(res_valid_out) &&
			$stable(exc_event_out) && $stable(exc_cause_out))
		else $error("state moved while the clock enable was low");

	conv_inexact_a: assert property (
		ce_in && op_valid_in && res_inexact_in &&
			(op_class_in == OP_FROM_INT || op_class_in == OP_TO_INT) |=>
			sticky_flags_out[FLG_PREC] && res_out == $past(bnd_res_in))
		else $error("inexact conversion did not set the precision flag");

	exact_quiet_a: assert property (
		ce_in && op_valid_in && !ranged && !res_inexact_in |=>
			!exc_event_out && exc_cause_out == '0)
		else $error("exact result raised a cause");

endmodule

// File: sfpx_scale_pack.sv
// sfpx_scale_pack: packs the exponent-scaled result handed to a trap.
// assumes: exponent is the unbounded one after rounding, unbiased.
`timescale 1ns/10ps
module sfpx_scale_pack import sfpx_pkg::*; (
	// unbounded result
	input wire logic dbl_in,
	input wire logic sign_in,
	input wire logic signed [EXP_W-1:0] exp_in,
	input wire logic [FRAC_W-1:0] frac_in,
	// scale up for underflow, down for overflow
	input wire logic scale_up_in,
	// result
	output logic [RES_W-1:0] res_out
);
	logic signed [EXP_W-1:0] scale;
	logic signed [EXP_W-1:0] biased;

	always_comb begin
		scale = dbl_in ? DBL_SCALE : SGL_SCALE;
		biased = exp_in + (dbl_in ? DBL_BIAS : SGL_BIAS) + (scale_up_in ? scale : -scale);
		if (dbl_in) begin
			res_out = {sign_in, biased[DBL_EXPF_W-1:0], frac_in};
		end else begin
			res_out = {{SGL_W{1'b0}}, sign_in, biased[SGL_EXPF_W-1:0],
				frac_in[FRAC_W-1:SGL_FRAC_LSB]};
		end
	end
endmodule

// File: tb_sfpx_post_exc.sv
// tb_sfpx_post_exc: self-checking bench for the post-computation exception unit.
// assumes: sfpx_pkg and the design files are compiled first; assertions live in the design.
`timescale 1ns/10ps
module tb_sfpx_post_exc import sfpx_pkg::*;;
	typedef struct packed {
		logic [63:0] r;
		logic [2:0] f;
		logic [2:0] c;
		logic ev;
	} sfpx_exp_type;
	logic ref_clk_in = 0;
	logic resetn_in = 0;
	logic ce_in = 0;
	logic ov = 0;
	logic dbl = 0;
	logic sg = 0;
	logic ri = 0;
	logic bi = 0;
	logic [1:0] rm = 0;
	logic [2:0] mk = 3'h7;
	logic [2:0] cl = 0;
	logic [2:0] stk = 0;
	sfpx_op_type cls = OP_ARITH;
	logic signed [EXP_W-1:0] ex = 0;
	logic [FRAC_W-1:0] fr = 0;
	logic [RES_W-1:0] br = 0;
	logic rv, ev;
	logic [RES_W-1:0] ro;
	logic [2:0] sf, ca;
	sfpx_exp_type q[$];
	sfpx_exp_type t;
	int err_total = 0;
	int checked = 0;
	int cyc = 0;

	always #5 ref_clk_in = ~ref_clk_in;

	sfpx_post_exc sfpx_post_exc_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.ce_in(ce_in), .ctl_rnd_mode_in(rm), .ctl_mask_in(mk), .flag_clear_in(cl),
		.op_valid_in(ov), .op_class_in(cls), .op_dbl_in(dbl), .res_sign_in(sg),
		.res_exp_in(ex), .res_frac_in(fr), .res_inexact_in(ri), .bnd_res_in(br),
		.bnd_inexact_in(bi), .res_valid_out(rv), .res_out(ro), .sticky_flags_out(sf),
		.exc_event_out(ev), .exc_cause_out(ca));

	task automatic chk(string n, logic [63:0] e, logic [63:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic results();
		$display("checked %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function automatic logic [51:0] rf();
		return 52'({$urandom(), $urandom()});
	endfunction

	// model and drive one op; mode and mask are whatever the caller left on the bus
	task automatic op(sfpx_op_type c, logic d, logic s, logic signed [13:0] e, logic [51:0] f,
		logic i, logic [63:0] b, logic bx, logic [2:0] z);
		logic sgl, rng, o, u, to, tu, inx, big, evx;
		logic [2:0] fl, cx;
		logic [63:0] r;
		logic signed [13:0] fe;
		sgl = !(d && c == OP_ARITH);
		rng = c == OP_ARITH || c == OP_NARROW;
		o = rng && e > (sgl ? SGL_EMAX : DBL_EMAX);
		u = rng && e < (sgl ? SGL_EMIN : DBL_EMIN);
		to = o && !mk[0];
		tu = u && !mk[1];
		big = rm == RND_ZERO || (rm == RND_DOWN && !s) || (rm == RND_UP && s);
		if (to || tu) begin
			fe = sgl ? (to ? e - SGL_SCALE : e + SGL_SCALE) + SGL_BIAS
				: (to ? e - DBL_SCALE : e + DBL_SCALE) + DBL_BIAS;
			r = sgl ? {32'h0, s, fe[7:0], f[51:29]} : {s, fe[10:0], f};
			fl = {i, tu, to};
			cx = to ? 3'h1 : 3'h2;
			evx = 1'b1;
		end else begin
			if (o)
				r = sgl ? {32'h0, s, big ? 31'h7F7FFFFF : 31'h7F800000}
					: {s, big ? 63'h7FEFFFFFFFFFFFFF : 63'h7FF0000000000000};
			else
				r = b;
			inx = o ? 1'b1 : u ? bx : i;
			fl = {inx, u && bx, o};
			evx = inx && !mk[2];
			cx = {evx, 2'h0};
		end
		ov = 1;
		cls = c;
		dbl = d;
		sg = s;
		ex = e;
		fr = f;
		ri = i;
		br = b;
		bi = bx;
		cl = z;
		stk = (stk & ~z) | fl;
		q.push_back('{r, stk, cx, evx});
		@(posedge ref_clk_in);
		#1;
	endtask

	task automatic idle();
		ov = 0;
		cl = 0;
		@(posedge ref_clk_in);
		#1;
	endtask

	// unexpected or unknown valid with an empty queue is caught as a stray result
	always @(negedge ref_clk_in) begin
		if (resetn_in && rv !== 1'b0) begin
			if (q.size() == 0) begin
				chk("stray result", 64'h0, 64'h1);
			end else begin
				t = q.pop_front();
				chk("result", t.r, ro);
				chk("sticky flags", 64'(t.f), 64'(sf));
				chk("cause", 64'(t.c), 64'(ca));
				chk("event", 64'(t.ev), 64'(ev));
			end
		end else if (resetn_in && ev !== 1'b0) begin
			chk("stray event", 64'h0, 64'h1);
		end
	end

	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			results();
		end
	end

	initial begin
		logic signed [13:0] e;
		logic sgl;
		sfpx_op_type c;
		logic [63:0] b;
		logic [2:0] mt [4];
		mt = '{3'h7, 3'h3, 3'h2, 3'h1};
		void'($urandom(32'h56DF));
		repeat (2) @(posedge ref_clk_in);
		#1;
		resetn_in = 1;
		ce_in = 1;
		chk("reset flags", 64'h0, 64'(sf));
		for (int i = 0; i < 16; i++) begin
			rm = i[1:0];
			op(OP_ARITH, i[3], i[2], i[3] ? 14'sh0400 : 14'sh0080, rf(), 0, 64'h0, 0, 0);
		end
		rm = RND_NEAREST;
		op(OP_ARITH, 0, 0, 14'sh007F, rf(), 1, 64'h3F80_0001, 0, 0);
		op(OP_ARITH, 0, 1, -14'sh007E, rf(), 0, 64'h8080_0000, 1, 0);
		op(OP_ARITH, 1, 0, 14'sh03FF, rf(), 0, 64'h7FE0_0000_0000_0000, 0, 0);
		op(OP_ARITH, 1, 0, -14'sh03FE, rf(), 0, 64'h0010_0000_0000_0000, 1, 0);
		op(OP_NARROW, 1, 0, 14'sh0100, rf(), 0, 64'h0, 0, 0);
		op(OP_ARITH, 1, 1, -14'sh044C, rf(), 0, 64'h8000_0000_0000_0001, 0, 0);
		op(OP_ARITH, 1, 0, -14'sh044C, rf(), 1, 64'h0000_0000_0000_0001, 1, 0);
		mk = 3'h4;
		for (int i = 0; i < 8; i++) begin
			c = i[2] ? OP_NARROW : OP_ARITH;
			sgl = !(i[0] && !i[2]);
			e = sgl ? (i[1] ? -14'sh00C8 : 14'sh00C8) : (i[1] ? -14'sh044C : 14'sh0500);
			op(c, i[0], 1'($urandom), e, rf(), 1'($urandom), 64'h0, 0, 0);
		end
		for (int j = 0; j < 4; j++) begin
			mk = mt[j];
			for (int i = 0; i < 6; i++) begin
				e = i % 3 == 0 ? 14'sh00C8 : i % 3 == 1 ? -14'sh00C8 : 14'sh0000;
				op(OP_ARITH, 0, 0, e, rf(), 1'(i / 3), 64'h0000_0001, 1'(i / 3), 0);
			end
		end
		for (int i = 0; i < 40; i++) begin
			mk = 3'($urandom);
			rm = 2'($urandom);
			c = sfpx_op_type'($urandom % 6);
			dbl = 0;
			sgl = !(i[0] && c == OP_ARITH);
			e = c > OP_NARROW ? 14'sh0 : sgl ? 14'(int'($urandom % 320) - 160)
				: 14'(int'($urandom % 2200) - 1100);
			b = sgl ? {32'h0, $urandom()} : {$urandom(), $urandom()};
			op(c, i[0], 1'($urandom), e, rf(), 1'($urandom), b, 1'($urandom), 3'($urandom));
		end
		mk = 3'h7;
		op(OP_ARITH, 0, 0, 14'sh0, rf(), 0, 64'h0, 0, 3'h7);
		op(OP_ARITH, 0, 0, 14'sh0080, rf(), 0, 64'h0, 0, 3'h7);
		// frozen clock enable must ignore both the op and the clear
		idle();
		ce_in = 0;
		ov = 1;
		cl = 3'h7;
		repeat (3) @(posedge ref_clk_in);
		#1;
		ov = 0;
		cl = 0;
		ce_in = 1;
		@(posedge ref_clk_in);
		#1;
		op(OP_ARITH, 0, 0, 14'sh0, rf(), 0, 64'h0, 0, 0);
		repeat (3) idle();
		chk("pending results", 64'h0, 64'(q.size()));
		results();
	end
endmodule
